// ### pkg/conv_out_pkg.sv
// shared constants and types for the decimated output back end
// assumes one sampling clock domain; serial clock arrives as a plain pin
package conv_out_pkg;
    localparam int RAW_W    = 14;
    localparam int SER_W    = 16;
    localparam int FIFO_DEP = 32;
    // register map, byte addresses on the 8-bit register port
    localparam logic [7:0] ADDR_FMT_A  = 8'h8F;
    localparam logic [7:0] ADDR_FMT_B  = 8'h92;
    localparam logic [7:0] ADDR_CFG    = 8'h90;
    localparam logic [7:0] ADDR_CTL    = 8'h91;
    localparam logic [7:0] ADDR_STAT   = 8'h93;
    localparam int FMT_OB_BIT   = 0;
    localparam int CFG_SYNC_EN  = 0;
    localparam int CFG_SERIAL   = 1;
    localparam int CFG_SDR      = 2;
    localparam int CFG_LANE_LO  = 3;
    localparam int CFG_DEC_LO   = 5;
    localparam int CTL_SYNC     = 0;
    localparam int CTL_RESTART  = 1;
    localparam int STAT_PD      = 0;
    localparam int STAT_MISSYNC = 1;
    localparam logic [7:0] CFG_RESET = 8'h20;
    localparam logic [1:0] LANE_TWO  = 2'h0;
    localparam logic [1:0] LANE_ONE  = 2'h1;
    localparam logic [1:0] LANE_HALF = 2'h2;
    localparam logic [5:0] BITS_TWO  = 6'h08;
    localparam logic [5:0] BITS_ONE  = 6'h10;
    localparam logic [5:0] BITS_HALF = 6'h20;
    localparam logic [5:0] SYNC_GRID = 6'h3F;

    typedef struct packed {
        logic [RAW_W-1:0] a;
        logic [RAW_W-1:0] b;
    } sample_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;
endpackage : conv_out_pkg

// ### src/conv_out.sv
// decimation clock sync, output coding and ddr/serial cmos formatting
// assumes clk is the sampling clock; register port is the decoded spi side
`timescale 1ns/1ps
`default_nettype none

module sample_fifo #(
    parameter int W   = 28,
    parameter int DEP = 32
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         flush,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEP);
    logic [W-1:0] mem [DEP];
    logic [AW:0]  wp;
    logic [AW:0]  rp;
    wire          push = in_valid & in_ready;
    wire          pop  = out_valid & out_ready;

    assign in_ready  = (wp - rp) != (AW+1)'(DEP);
    assign out_valid = wp != rp;
    assign out_data  = mem[rp[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push)
            mem[wp[AW-1:0]] <= in_data;
    end

    always_ff @(posedge clk) begin
        if (sys_rst || flush) begin
            wp <= '0;
            rp <= '0;
        end else begin
            wp <= wp + (AW+1)'(push);
            rp <= rp + (AW+1)'(pop);
        end
    end

    a_fifo_full_stall: assert property (@(posedge clk) disable iff (sys_rst)
        (wp - rp) == (AW+1)'(DEP) |-> !in_ready)
        else $error("fifo accepts data while full");
endmodule : sample_fifo

// Function
// - sync pin sampled on clock, role chosen by bit
// - sync from register write or sync pin
// - sync resets dividers and aligns both channels
// - sync restarts oscillator phase, loads new frequency
// - no sync means dividers free-run unaligned
// - parallel decimated output is real, 14-bit
// - ddr clock is fs/M, data at twice
// - parallel data clock generated internally
// - serial lanes selectable two, one, half
// - 16-bit serial uses 8x, 16x or 32x
// - complex serial rates follow lanes and decimation
// - real serial rates follow lanes and decimation
// - default serial launches on both clock edges
// - sdr mode launches on rising edges only
// - sdr divides serial input clock by two
// - per-channel coding two's complement or offset
// - 14-bit codes span full range correctly
// - 16-bit codes span full range correctly
module conv_out (
    input  wire logic                          clk,
    input  wire logic                          sys_rst,
    input  wire conv_out_pkg::reg_req_t        reg_req,
    output logic [7:0]                         reg_rdata,
    input  wire logic                          powerdown_sync_pin,
    input  wire logic                          serial_clock_in,
    input  wire logic                          sample_valid,
    output logic                               sample_ready,
    input  wire conv_out_pkg::sample_t         sample_in,
    output logic                               powerdown,
    output logic                               tuning_oscillator_restart,
    output logic                               decim_strobe,
    output logic                               data_clock_out,
    output logic                               frame_clock_out,
    output logic [conv_out_pkg::RAW_W-1:0]     parallel_data,
    output logic [3:0]                         serial_lanes
);
    import conv_out_pkg::*;

    function automatic logic [SER_W-1:0] code16(
        input logic [RAW_W-1:0] x,
        input logic             ob
    );
        logic [SER_W-1:0] v;
        v = {x, {(SER_W-RAW_W){1'b0}}};
        code16 = {v[SER_W-1] ^ ob, v[SER_W-2:0]};
    endfunction : code16

    logic [7:0] fmt_a;
    logic [7:0] fmt_b;
    logic [7:0] cfg;
    logic       missync;
    logic       pin_m;
    logic       pin_s;
    logic       pin_d;
    logic       sck_m;
    logic       sck_s;
    logic       sck_d;
    logic       sdr_div;
    logic [4:0] div_cnt;
    logic [5:0] grid_cnt;
    logic [5:0] bit_cnt;
    logic [31:0] shreg;
    logic       sync_evt;
    logic       fifo_valid;
    logic       fifo_pop;
    sample_t    fifo_word;
    sample_t    held;
    logic [31:0] load_word_q;

    wire        sync_en   = cfg[CFG_SYNC_EN];
    wire        serial    = cfg[CFG_SERIAL];
    wire        sdr_en    = cfg[CFG_SDR];
    wire [1:0]  lanes     = cfg[CFG_LANE_LO +: 2];
    wire [2:0]  dec_log   = cfg[CFG_DEC_LO +: 3];
    wire [4:0]  dec_last  = 5'((6'h01 << dec_log) - 6'h01);
    wire [4:0]  dec_half  = 5'((6'h01 << dec_log) >> 1);
    wire        wr_ctl    = reg_req.wr && reg_req.addr == ADDR_CTL;
    wire        pin_rise  = pin_s & ~pin_d;
    wire        sck_edge  = sck_s ^ sck_d;
    wire        sck_rise  = sck_s & ~sck_d;
    wire        sdr_tick  = sck_rise & ~sdr_div;
    wire        ser_tick  = serial & (sdr_en ? sdr_tick : sck_edge);
    wire        frame_end = bit_cnt == 6'h00;
    wire [5:0]  bits_fr   = lanes == LANE_TWO ? BITS_TWO :
                            lanes == LANE_ONE ? BITS_ONE : BITS_HALF;
    wire        ser_load  = ser_tick & frame_end & fifo_valid;
    wire        par_rise  = ~serial & div_cnt == 5'h00;
    wire        par_fall  = ~serial & div_cnt == dec_half;
    wire [31:0] load_word = {code16(fifo_word.a, fmt_a[FMT_OB_BIT]),
                             code16(fifo_word.b, fmt_b[FMT_OB_BIT])};
    // with nothing queued the last pair is repeated rather than stale memory
    wire [RAW_W-1:0] par_a = fifo_valid ? fifo_word.a : held.a;
    wire [31:0] next_sh   = ser_load ? load_word :
                            ser_tick ? {shreg[30:0], 1'b0} : shreg;
    wire [5:0]  next_cnt  = ser_load ? bits_fr - 6'h01 :
                            (ser_tick & ~frame_end) ? bit_cnt - 6'h01
                                                    : bit_cnt;
    // two-wire splits each channel into halves, half-wire chains a then b
    wire [3:0]  next_lane = {lanes == LANE_TWO & next_sh[7],
                             lanes != LANE_HALF & next_sh[15],
                             lanes == LANE_TWO & next_sh[23],
                             next_sh[31]};
    wire        next_data_clock_out = ~serial ? (par_rise | (data_clock_out & ~par_fall))
                          : sdr_en  ? (sdr_div ^ sck_rise) : sck_s;

    // the first stage of each synchroniser feeds only the second
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            {pin_m, pin_s, pin_d} <= 3'h0;
            {sck_m, sck_s, sck_d} <= 3'h0;
        end else begin
            pin_m <= powerdown_sync_pin;
            pin_s <= pin_m;
            pin_d <= pin_s;
            sck_m <= serial_clock_in;
            sck_s <= sck_m;
            sck_d <= sck_s;
        end
    end

    // pin captured on clk, role chosen by the enable bit
    assign sync_evt = (sync_en & pin_rise) | (wr_ctl & reg_req.wdata[CTL_SYNC]);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fmt_a <= 8'h00;
            fmt_b <= 8'h00;
            cfg   <= CFG_RESET;
        end else if (reg_req.wr) begin
            if (reg_req.addr == ADDR_FMT_A)
                fmt_a <= reg_req.wdata;
            if (reg_req.addr == ADDR_FMT_B)
                fmt_b <= reg_req.wdata;
            if (reg_req.addr == ADDR_CFG)
                cfg <= reg_req.wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (reg_req.rd) begin
            unique case (reg_req.addr)
                ADDR_FMT_A: reg_rdata <= fmt_a;
                ADDR_FMT_B: reg_rdata <= fmt_b;
                ADDR_CFG:   reg_rdata <= cfg;
                ADDR_STAT:  reg_rdata <= {6'h00, missync, powerdown};
                default:    reg_rdata <= 8'h00;
            endcase
        end
    end

    // divider free-runs until a sync lands; devices stay misaligned until then
    always_ff @(posedge clk) begin
        if (sys_rst || sync_evt || div_cnt >= dec_last)
            div_cnt <= 5'h00;
        else
            div_cnt <= div_cnt + 5'h01;
    end

    // a sync off the 64-cycle grid is flagged; a new miss beats the clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            grid_cnt <= 6'h00;
            missync  <= 1'b0;
        end else begin
            grid_cnt <= grid_cnt + 6'h01;
            if (sync_evt && grid_cnt != SYNC_GRID)
                missync <= 1'b1;
            else if (reg_req.wr && reg_req.addr == ADDR_STAT &&
                     reg_req.wdata[STAT_MISSYNC])
                missync <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            powerdown                 <= 1'b0;
            tuning_oscillator_restart <= 1'b0;
            decim_strobe              <= 1'b0;
        end else begin
            powerdown                 <= ~sync_en & pin_s;
            tuning_oscillator_restart <= sync_evt |
                (wr_ctl & reg_req.wdata[CTL_RESTART]);
            decim_strobe              <= ~sync_evt & div_cnt == dec_last;
        end
    end

    // a and b enter together at the decimated rate so they stay paired
    sample_fifo #(
        .W   ($bits(sample_t)),
        .DEP (FIFO_DEP)
    ) u_fifo (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .flush     (sync_evt),
        .in_valid  (sample_valid & decim_strobe),
        .in_ready  (sample_ready),
        .in_data   (sample_in),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_word)
    );
    assign fifo_pop = ser_load | (par_rise & fifo_valid);

    // the popped pair is kept so the falling half still sees channel b
    always_ff @(posedge clk) begin
        if (sys_rst)
            held <= '0;
        else if (fifo_pop)
            held <= fifo_word;
    end

    always_ff @(posedge clk) begin
        if (sys_rst)
            sdr_div <= 1'b0;
        else if (sck_rise)
            sdr_div <= ~sdr_div;
    end

    always_ff @(posedge clk) begin
        if (sys_rst || sync_evt) begin
            shreg        <= 32'h0000_0000;
            bit_cnt      <= 6'h00;
            serial_lanes <= 4'h0;
        end else begin
            shreg        <= next_sh;
            bit_cnt      <= next_cnt;
            serial_lanes <= next_lane;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            data_clock_out  <= 1'b0;
            frame_clock_out <= 1'b0;
            parallel_data   <= '0;
        end else begin
            data_clock_out  <= next_data_clock_out;
            frame_clock_out <= serial & next_cnt >= (bits_fr >> 1);
            if (par_rise)
                parallel_data <= par_a ^
                    {fmt_a[FMT_OB_BIT], {(RAW_W-1){1'b0}}};
            else if (par_fall)
                parallel_data <= held.b ^
                    {fmt_b[FMT_OB_BIT], {(RAW_W-1){1'b0}}};
        end
    end

    sequence s_pin_rise;
        sync_en && pin_rise;
    endsequence

    a_pin_sync_evt: assert property (@(posedge clk) disable iff (sys_rst)
        s_pin_rise |=> div_cnt == 5'h00 && tuning_oscillator_restart)
        else $error("pin sync did not reset divider and oscillator");
    a_pin_powerdown: assert property (@(posedge clk) disable iff (sys_rst)
        !sync_en ##1 !$past(sync_en) |-> powerdown == $past(pin_s))
        else $error("powerdown does not follow pin");
    a_reg_sync_osc: assert property (@(posedge clk) disable iff (sys_rst)
        wr_ctl && reg_req.wdata[CTL_SYNC] |=> tuning_oscillator_restart)
        else $error("register sync missed oscillator restart");
    a_div_wrap: assert property (@(posedge clk) disable iff (sys_rst)
        !sync_evt && div_cnt == dec_last && $stable(cfg)
        |=> div_cnt == 5'h00 && decim_strobe)
        else $error("divider wrap wrong");
    a_sdr_rise_only: assert property (@(posedge clk) disable iff (sys_rst)
        serial && sdr_en && $changed(serial_lanes) && !$past(sync_evt)
        && $past(serial && sdr_en) |-> $rose(data_clock_out))
        else $error("sdr data launched off rising edge");
    a_frame_msb: assert property (@(posedge clk) disable iff (sys_rst)
        ser_load && !sync_evt |=> serial_lanes[0] == load_word_q[31])
        else $error("frame does not start with msb");
    a_grid_flag: assert property (@(posedge clk) disable iff (sys_rst)
        sync_evt && grid_cnt != SYNC_GRID |=> missync)
        else $error("off-grid sync not flagged");
    a_ddr_half: assert property (@(posedge clk) disable iff (sys_rst)
        par_rise && !sync_evt && $stable(cfg) ##1 $stable(cfg)
        |-> data_clock_out)
        else $error("ddr clock did not rise at divider zero");

    always_ff @(posedge clk) begin
        load_word_q <= load_word;
    end
endmodule : conv_out

`default_nettype wire

// ### test/cmos_rx_model.sv
// far-side receiver: makes the serial clock and captures lanes 0 and 2
// assumes one-wire framing, 16 bits a lane, msb first, clk-locked
`timescale 1ns/1ps
`default_nettype none
module cmos_rx_model (
    input  wire logic        clk,
    input  wire logic        run,
    input  wire logic        sdr,
    input  wire logic        data_clock_out,
    input  wire logic        frame_clock_out,
    input  wire logic [3:0]  serial_lanes,
    output logic             serial_clock_in,
    output logic [15:0]      word_a,
    output logic [15:0]      word_b
);
    logic [2:0]  div = 3'h0;
    logic        dck_q = 1'b0;
    logic        frm_q = 1'b0;
    logic [15:0] sh_a, sh_b;
    logic [4:0]  cnt = 5'h00;
    wire         dck_edge = sdr ? (data_clock_out & ~dck_q)
                                : (data_clock_out ^ dck_q);
    // derived from clk so it stays frequency locked; stands still when idle
    always @(posedge clk) begin
        div <= run ? div + 3'h1 : 3'h0;
        serial_clock_in <= run & (sdr ? div[1] : div[2]);
    end
    always @(posedge clk) begin
        dck_q <= data_clock_out;
        frm_q <= frame_clock_out;
        if (frame_clock_out && !frm_q) begin
            sh_a <= {15'h0, serial_lanes[0]};
            sh_b <= {15'h0, serial_lanes[2]};
            cnt <= 5'h01;
        end else if (dck_edge && cnt != 5'h00) begin
            sh_a <= {sh_a[14:0], serial_lanes[0]};
            sh_b <= {sh_b[14:0], serial_lanes[2]};
            cnt <= (cnt == 5'h0F) ? 5'h00 : cnt + 5'h01;
            if (cnt == 5'h0F) begin
                word_a <= {sh_a[14:0], serial_lanes[0]};
                word_b <= {sh_b[14:0], serial_lanes[2]};
            end
        end
    end
endmodule : cmos_rx_model
`default_nettype wire

// ### test/conv_out_tb.sv
// self-checking bench for the decimated output back end
// assumes conv_out_pkg and the receiver model are compiled first
`timescale 1ns/1ps
`default_nettype none
module conv_out_tb;
    import conv_out_pkg::*;
    logic             clk = 1'b0, sys_rst = 1'b1, pin = 1'b0;
    logic             run = 1'b0, sdr = 1'b0, sample_valid = 1'b0;
    logic             sclk, sample_ready, pd, rst_osc, strobe, dco, fco;
    reg_req_t         reg_req = '0;
    sample_t          sample_in = '0;
    logic [7:0]       rdata;
    logic [RAW_W-1:0] pdata;
    logic [3:0]       lanes;
    logic [15:0]      wa, wb;
    int               error_cnt = 0, n_checks = 0, cyc = 0, n_rst = 0;

    always #2.5 clk = ~clk;

    conv_out conv_out_i (.clk(clk), .sys_rst(sys_rst), .reg_req(reg_req),
        .reg_rdata(rdata), .powerdown_sync_pin(pin), .serial_clock_in(sclk),
        .sample_valid(sample_valid), .sample_ready(sample_ready),
        .sample_in(sample_in), .powerdown(pd),
        .tuning_oscillator_restart(rst_osc), .decim_strobe(strobe),
        .data_clock_out(dco), .frame_clock_out(fco),
        .parallel_data(pdata), .serial_lanes(lanes));
    cmos_rx_model cmos_rx_model_i (.clk(clk), .run(run), .sdr(sdr),
        .data_clock_out(dco), .frame_clock_out(fco), .serial_lanes(lanes),
        .serial_clock_in(sclk), .word_a(wa), .word_b(wb));

    always @(posedge clk) if (rst_osc === 1'b1) n_rst <= n_rst + 1;

    task automatic end_of_test;
        $display("checks %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    // the ceiling sits well above the few hundred cycles the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            end_of_test;
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, d);
        @(posedge clk) reg_req <= '{1'b1, 1'b0, a, d};
        @(posedge clk) reg_req <= '0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk) reg_req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk) reg_req <= '0;
        @(negedge clk) d = rdata;
    endtask : rd

    // valid stays up until the strobe edge that takes the pair
    task automatic push(input logic [13:0] a, b);
        int t;
        t = 0;
        @(posedge clk) begin
            sample_in <= '{a, b};
            sample_valid <= 1'b1;
        end
        do @(posedge clk);
        while (!(strobe === 1'b1 && sample_ready === 1'b1) && ++t < 100);
        sample_valid <= 1'b0;
    endtask : push

    task automatic wait_dco(input logic v, output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (dco !== v && n < 200);
    endtask : wait_dco

    task automatic t_regs;
        logic [7:0] d;
        rd(ADDR_CFG, d);  chk("cfg reset", 16'(CFG_RESET), 16'(d));
        rd(ADDR_FMT_A, d); chk("fmt a reset", 16'h0000, 16'(d));
        rd(ADDR_FMT_B, d); chk("fmt b reset", 16'h0000, 16'(d));
        rd(ADDR_CTL, d);  chk("ctl read", 16'h0000, 16'(d));
        rd(8'h55, d);     chk("unmapped read", 16'h0000, 16'(d));
        wr(ADDR_FMT_A, 8'h01);
        rd(ADDR_FMT_A, d); chk("fmt a back", 16'h0001, 16'(d));
        $display("test regs done");
    endtask : t_regs

    task automatic t_sync;
        int k;
        logic [7:0] d;
        k = n_rst;
        wr(ADDR_CTL, 8'h01);
        repeat (4) @(posedge clk);
        chk("restart by sync bit", 16'h1, 16'(n_rst - k));
        wr(ADDR_CTL, 8'h02);
        repeat (4) @(posedge clk);
        chk("restart by restart bit", 16'h2, 16'(n_rst - k));
        @(posedge clk) pin <= 1'b1;
        repeat (8) @(posedge clk);
        chk("pin as powerdown", 16'h1, 16'(pd));
        chk("no sync from pin", 16'h2, 16'(n_rst - k));
        rd(ADDR_STAT, d);
        chk("status powerdown", 16'h1, 16'(d[STAT_PD]));
        @(posedge clk) pin <= 1'b0;
        wr(ADDR_CFG, 8'h21);
        repeat (8) @(posedge clk);
        pin <= 1'b1;
        repeat (8) @(posedge clk);
        chk("restart by sync pin", 16'h3, 16'(n_rst - k));
        chk("sync pin no powerdown", 16'h0, 16'(pd));
        pin <= 1'b0;
        wr(ADDR_CFG, 8'h20);
        wr(ADDR_STAT, 8'h02);
        rd(ADDR_STAT, d);
        chk("off-grid flag clear", 16'h0, 16'(d[STAT_MISSYNC]));
        $display("test sync done");
    endtask : t_sync

    // channel a on the rising half, b on the falling half
    task automatic t_par(input logic [13:0] a, b, ea, eb);
        int n;
        push(a, b);
        repeat (12) @(posedge clk);
        wait_dco(1'b0, n);
        wait_dco(1'b1, n);
        chk("ddr rising half", 16'(ea), 16'(pdata));
        wait_dco(1'b0, n);
        chk("ddr falling half", 16'(eb), 16'(pdata));
        $display("test parallel done");
    endtask : t_par

    task automatic t_period(input logic [7:0] cfg, input int m);
        int n0, n1;
        wr(ADDR_CFG, cfg);
        repeat (2) begin
            wait_dco(1'b0, n0);
            wait_dco(1'b1, n0);
        end
        wait_dco(1'b0, n0);
        wait_dco(1'b1, n1);
        chk("ddr clock period", 16'(m), 16'(n0 + n1));
        $display("test period done");
    endtask : t_period

    task automatic t_ser(input logic [7:0] cfg, input logic s,
                         input logic [13:0] a, b, input logic [15:0] ea, eb);
        int t;
        @(posedge clk) begin
            sdr <= s;
            run <= 1'b1;
        end
        wr(ADDR_CFG, cfg);
        repeat (40) @(posedge clk);
        wr(ADDR_CTL, 8'h01);
        push(a, b);
        t = 0;
        do @(negedge clk); while (wa !== ea && ++t < 800);
        chk("serial lane a", ea, wa);
        chk("serial lane b", eb, wb);
        $display("test serial done");
    endtask : t_ser

    initial begin
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs;
        t_sync;
        t_par(14'h2000, 14'h1FFF, 14'h0000, 14'h1FFF);
        t_par(14'h1FFF, 14'h2000, 14'h3FFF, 14'h2000);
        t_par(14'h0000, 14'h0000, 14'h2000, 14'h0000);
        t_period(8'h20, 2);
        t_period(8'h60, 8);
        t_ser(8'h2A, 1'b0, 14'h1FFF, 14'h2000, 16'hFFFC, 16'h8000);
        t_ser(8'h2E, 1'b1, 14'h0000, 14'h3FFF, 16'h8000, 16'hFFFC);
        end_of_test;
    end
endmodule : conv_out_tb
`default_nettype wire
